// ==== core/apg_defs.vh ====
`ifndef APG_DEFS_VH
`define APG_DEFS_VH

// Register addresses
`define APG_ADDR_MOD 5'h08
`define APG_ADDR_PHASE 5'h0a
`define APG_ADDR_GAIN 5'h0b

// Reset values
`define APG_MOD_RESET 24'h003333
`define APG_PHASE_RESET 24'h000000
`define APG_GAIN_RESET 24'h000000
`define APG_GAIN_SHIFT_RESET 24'h041041

// Field positions
`define APG_MOD_IMPL_MSB 15
`define APG_PHASE_HI_LSB 12
`define APG_GAIN_IMPL_MSB 11

// Gain codes
`define APG_GAIN_CODE_MAX 3'h5

// Restart pulse length in modulator clock periods
`define APG_RESTART_PERIODS 4'h2

`endif

// ==== core/apg_delay_line.v ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Programmable start delay for one channel
// ----------------------------------------
module apg_delay_line (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Control
  input wire restart,
  input wire mod_tick,
  input wire [11:0] delay_code,
  // Status
  output reg running
);

  reg [11:0] count;

  always @(posedge clk)
  begin
    if (srst || restart)
    begin
      count <= 12'h000;
      running <= 1'b0;
    end
    // Start once the count is reached, so code zero adds no lag
    else if (!running)
    begin
      if (count == delay_code)
        running <= 1'b1;
      else if (mod_tick)
        count <= count + 12'h001;
    end
  end

endmodule

`default_nettype wire

// ==== core/apg_regs.v ====
`timescale 1ns/1ps
`default_nettype none
`include "apg_defs.vh"

// Summary of operation
// - Modulator register bits 23-16 read zero
// - Four comparator bits per channel, ch0 lowest
// - Modulator register refreshed every modulator period
// - Any phase write restarts active converters
// - High code delays ch2 behind ch3
// - Low code delays ch0 behind ch1
// - Gain register bits 23-12 read zero
// - Three-bit gain code per channel
// - Codes 6 and 7 give gain one
module apg_regs (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Register access from serial port
  input wire [4:0] reg_addr,
  input wire reg_wr,
  input wire [23:0] reg_wdata,
  output reg [23:0] reg_rdata,
  // Modulator side
  input wire modulator_clock,
  input wire [3:0] comparator_bits_ch0,
  input wire [3:0] comparator_bits_ch1,
  input wire [3:0] comparator_bits_ch2,
  input wire [3:0] comparator_bits_ch3,
  input wire [3:0] channel_enable,
  // Converter control
  output reg [3:0] channel_reset,
  output reg [3:0] channel_run,
  output reg [23:0] gain_shift,
  output reg [11:0] channel_gain_code
);

  reg [15:0] mod_bits;
  reg [11:0] delay_code_pair_hi;
  reg [11:0] delay_code_pair_lo;
  reg [2:0] mclk_sync;
  reg mclk_prev;
  reg restart;
  reg [3:0] restart_periods;
  wire mod_tick;
  wire run_ref;
  wire run_ch0;
  wire run_ch2;
  integer i;

  // Full-width reset words, sliced to the implemented fields
  localparam [23:0] mod_reset_word = `APG_MOD_RESET;
  localparam [23:0] phase_reset_word = `APG_PHASE_RESET;
  localparam [23:0] gain_reset_word = `APG_GAIN_RESET;

  // ----------------------------------------
  // Gain decode
  // ----------------------------------------
  // gain code to shift
  function [5:0] gain_onehot;
    input [2:0] code;
    begin
      if (code > `APG_GAIN_CODE_MAX)
        gain_onehot = 6'h01;
      else
        gain_onehot = 6'h01 << code;
    end
  endfunction

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  function write_hit;
    input wr;
    input [4:0] addr;
    input [4:0] target;
    begin
      write_hit = wr && (addr == target);
    end
  endfunction

  // ----------------------------------------
  // Modulator clock edge detect
  // ----------------------------------------
  // Edge taken once stages two and three agree
  always @(posedge clk)
  begin
    if (srst)
    begin
      mclk_sync <= 3'h0;
      mclk_prev <= 1'b0;
    end
    else
    begin
      mclk_sync <= {mclk_sync[1:0], modulator_clock};
      if (mclk_sync[2] == mclk_sync[1])
        mclk_prev <= mclk_sync[2];
    end
  end

  assign mod_tick = (mclk_sync[2] == mclk_sync[1]) && mclk_sync[2] && !mclk_prev;

  // ----------------------------------------
  // Register writes and refresh
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (srst)
    begin
      mod_bits <= mod_reset_word[15:0];
      delay_code_pair_hi <= phase_reset_word[23:12];
      delay_code_pair_lo <= phase_reset_word[11:0];
      channel_gain_code <= gain_reset_word[11:0];
    end
    else
    begin
      if (mod_tick)
        mod_bits <= {comparator_bits_ch3, comparator_bits_ch2,
                     comparator_bits_ch1, comparator_bits_ch0};
      else if (write_hit(reg_wr, reg_addr, `APG_ADDR_MOD))
        mod_bits <= reg_wdata[`APG_MOD_IMPL_MSB:0];
      if (write_hit(reg_wr, reg_addr, `APG_ADDR_PHASE))
      begin
        delay_code_pair_hi <= reg_wdata[23:`APG_PHASE_HI_LSB];
        delay_code_pair_lo <= reg_wdata[11:0];
      end
      if (write_hit(reg_wr, reg_addr, `APG_ADDR_GAIN))
        channel_gain_code <= reg_wdata[`APG_GAIN_IMPL_MSB:0];
    end
  end

  // ----------------------------------------
  // Restart sequence
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (srst)
    begin
      restart <= 1'b0;
      restart_periods <= 4'h0;
    end
    else if (write_hit(reg_wr, reg_addr, `APG_ADDR_PHASE))
    begin
      restart <= 1'b1;
      restart_periods <= 4'h0;
    end
    else if (restart && mod_tick)
    begin
      if (restart_periods == `APG_RESTART_PERIODS - 4'h1)
        restart <= 1'b0;
      restart_periods <= restart_periods + 4'h1;
    end
  end

  // ----------------------------------------
  // Channel start delays
  // ----------------------------------------
  // Zero-code line for the references, so both sides see equal latency
  apg_delay_line u_delay_ref (
    .clk(clk),
    .srst(srst),
    .restart(restart),
    .mod_tick(mod_tick),
    .delay_code(12'h000),
    .running(run_ref)
  );

  apg_delay_line u_delay_lo (
    .clk(clk),
    .srst(srst),
    .restart(restart),
    .mod_tick(mod_tick),
    .delay_code(delay_code_pair_lo),
    .running(run_ch0)
  );

  apg_delay_line u_delay_hi (
    .clk(clk),
    .srst(srst),
    .restart(restart),
    .mod_tick(mod_tick),
    .delay_code(delay_code_pair_hi),
    .running(run_ch2)
  );

  // Only enabled channels are reset and restarted
  always @(posedge clk)
  begin
    if (srst)
    begin
      channel_reset <= 4'h0;
      channel_run <= 4'h0;
    end
    else
    begin
      channel_reset <= {4{restart}} & channel_enable;
      channel_run <= {run_ref, run_ch2, run_ref, run_ch0} & channel_enable;
    end
  end

  // ----------------------------------------
  // Gain outputs
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (srst)
      gain_shift <= `APG_GAIN_SHIFT_RESET;
    else
      for (i = 0; i < 4; i = i + 1)
        gain_shift[i*6 +: 6] <= gain_onehot(channel_gain_code[i*3 +: 3]);
  end

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (srst)
      reg_rdata <= 24'h000000;
    else
      case (reg_addr)
        `APG_ADDR_MOD: reg_rdata <= {8'h00, mod_bits};
        `APG_ADDR_PHASE: reg_rdata <= {delay_code_pair_hi, delay_code_pair_lo};
        `APG_ADDR_GAIN: reg_rdata <= {12'h000, channel_gain_code};
        default: reg_rdata <= 24'h000000;
      endcase
  end

endmodule

`default_nettype wire

// ==== tb/apg_mod_src.sv ====
`timescale 1ns/1ps
`default_nettype none
module apg_mod_src (
  // Modulator side
  input wire logic clk,
  output logic mclk,
  output logic [15:0] bits
);
  integer seed = 52;
  initial
  begin
    mclk = 1'b0;
    bits = 16'h3333;
    forever
    begin
      repeat (8) @(negedge clk);
      mclk = ~mclk;
      // Move bits on the fall, clear of the sampled rise
      if (!mclk)
        bits = $random(seed);
    end
  end
endmodule
`default_nettype wire

// ==== tb/apg_regs_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module apg_regs_sva (
  // Watched ports
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  input wire logic [3:0] channel_enable,
  input wire logic [3:0] channel_reset,
  input wire logic [3:0] channel_run,
  input wire logic [23:0] gain_shift,
  input wire logic [11:0] channel_gain_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [23:0] phase_seen;
  always @(posedge clk)
    if (srst)
      phase_seen <= 24'h000000;
    else if (reg_wr && reg_addr == 5'h0a)
      phase_seen <= reg_wdata;
  function automatic logic [5:0] sh(input logic [2:0] c);
    sh = (c > 3'h5) ? 6'h01 : 6'h01 << c;
  endfunction
  mod_top_zero_a: assert property ($past(reg_addr) == 5'h08 |-> reg_rdata[23:16] == 8'h00)
    else $error("mod top set");
  gain_top_zero_a: assert property ($past(reg_addr) == 5'h0b |-> reg_rdata[23:12] == 12'h000)
    else $error("gain top set");
  gain_write_a: assert property (reg_wr && reg_addr == 5'h0b ##1 !reg_wr
    |-> ##1 channel_gain_code == $past(reg_wdata[11:0], 2)) else $error("gain write");
  gain_lo_map_a: assert property ($stable(channel_gain_code)
    |-> gain_shift[5:0] == sh(channel_gain_code[2:0])) else $error("gain ch0");
  gain_hi_map_a: assert property ($stable(channel_gain_code)
    |-> gain_shift[23:18] == sh(channel_gain_code[11:9])) else $error("gain ch3");
  phase_restart_a: assert property (reg_wr && reg_addr == 5'h0a && channel_enable != 4'h0
    |-> ##[1:3] channel_reset == channel_enable) else $error("no restart");
  lo_pair_lag_a: assert property ($rose(channel_run[1])
    |-> channel_run[0] == (phase_seen[11:0] == 12'h000 && channel_enable[0]))
    else $error("ch0 lag wrong");
  hi_pair_lag_a: assert property ($rose(channel_run[3])
    |-> channel_run[2] == (phase_seen[23:12] == 12'h000 && channel_enable[2]))
    else $error("ch2 lag wrong");
endmodule
bind apg_regs apg_regs_sva u_sva (.clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
  .channel_enable, .channel_reset, .channel_run, .gain_shift, .channel_gain_code);
`default_nettype wire

// ==== tb/test_apg_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_apg_regs;
  logic clk, srst, reg_wr, mclk;
  logic [4:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata, gain_shift, d;
  logic [3:0] channel_enable, channel_reset, channel_run;
  logic [11:0] channel_gain_code;
  logic [15:0] bits;
  integer failures = 0, n_compared = 0, seed = 52, i, t0, t1, t2;
  apg_regs u_dut (.clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
    .modulator_clock(mclk), .comparator_bits_ch0(bits[3:0]), .comparator_bits_ch1(bits[7:4]),
    .comparator_bits_ch2(bits[11:8]), .comparator_bits_ch3(bits[15:12]),
    .channel_enable, .channel_reset, .channel_run, .gain_shift, .channel_gain_code);
  apg_mod_src u_mod (.clk, .mclk, .bits);
  function automatic logic [5:0] sh(input logic [2:0] c);
    sh = (c > 3'h5) ? 6'h01 : 6'h01 << c;
  endfunction
  task cmp(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [23:0] v);
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [4:0] a, input logic [23:0] e);
    @(negedge clk);
    reg_addr = a;
    repeat (2) @(negedge clk);
    cmp(reg_rdata, e);
  endtask
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    #60000;
    failures++;
    close_out;
  end
  initial
  begin
    {srst, reg_wr, reg_addr, reg_wdata, channel_enable} = {1'b1, 1'b0, 5'h08, 24'h0, 4'hf};
    repeat (5) @(negedge clk);
    srst = 1'b0;
    rd(5'h0a, 24'h000000);
    rd(5'h0b, 24'h000000);
    reg_addr = 5'h08;
    for (i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      repeat (7) @(negedge clk);
      cmp(reg_rdata, {8'h00, bits});
    end
    $display("modulator test done");
    for (i = 0; i < 8; i++)
    begin
      d = $random(seed);
      wr(5'h0b, {d[23:12], {4{i[2:0]}}});
      rd(5'h0b, {12'h000, {4{i[2:0]}}});
      cmp(gain_shift, {4{sh(i[2:0])}});
      wr(5'h0b, d);
      rd(5'h0b, d & 24'h000fff);
      d = $random(seed);
      wr(5'h0a, d);
      rd(5'h0a, d);
    end
    $display("gain and phase test done");
    wr(5'h0a, {12'h005, 12'h002});
    {t0, t1, t2} = 0;
    for (i = 0; i < 600; i++)
    begin
      @(negedge clk);
      if (!channel_run[1]) t0 = i;
      if (!channel_run[0]) t1 = i;
      if (!channel_run[2]) t2 = i;
    end
    // One modulator period is 16 clocks here
    cmp(24'(t1 - t0), 24'd32);
    cmp(24'(t2 - t0), 24'd80);
    $display("delay test done");
    channel_enable = 4'h5;
    wr(5'h0a, 24'h000000);
    @(negedge clk);
    cmp({20'h00000, channel_reset}, 24'h000005);
    repeat (100) @(negedge clk);
    cmp({20'h00000, channel_reset}, 24'h000000);
    cmp({20'h00000, channel_run}, 24'h000005);
    $display("enable test done");
    close_out;
  end
endmodule
`default_nettype wire
